// File: hdl/async_timer.sv
`timescale 1ns/10ps
`include "async_timer_params.svh"

// Overview of operation
// - enable bit 15 runs the timer; cleared, the timer stops
// - idle-stop bit 13 halts counting while idle; clear keeps counting
// - write-block set: counter writes ignored while an async write pends
// - write-block clear: counter writes accepted back to back
// - write-pending bit 11 reads one while an async counter write transfers
// - in synchronous operation write-pending always reads zero
// - gate bit 7 enables gated counting only with the internal clock
// - prescale bits 5-4: 11 /256, 10 /64, 01 /8, 00 /1
// - sync bit 2 selects synchronized external clock; ignored with internal
// - clock-source bit 1 selects external pin, else internal clock
// - aliases at +4, +8, +C clear, set, invert the bits written one in control, count and period
// - unimplemented bits, including bits 31-16, read as zero
// - four modes: internal, gated internal, sync external, async external
module async_timer (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        idle_mode,
  input  wire logic        external_timer_clock_pin,
  input  wire logic        gate_pin,
  output logic             timer_irq
);

  async_timer_pkg::state_t s_q;
  async_timer_pkg::state_t s_d;

  logic        ext_edge;
  logic        gate_lvl;
  logic        src_tick;
  logic        ps_tick;
  logic        run;
  logic        async_mode;
  logic [7:0]  ps_tc;
  logic [15:0] ctl_rd;
  logic [15:0] base_val;
  logic [15:0] new_val;
  logic [15:0] wd16;
  logic [1:0]  alias_sel;
  logic [15:0] reg_ofs;
  logic        acc;
  logic        wr_go;
  logic        rd_go;
  logic        cnt_wr;
  logic [1:0]  ev;

  // ----------------------------------------
  // clock source and prescaler
  // ----------------------------------------
  always_comb begin
    ext_edge   = s_q.pin_s[1] & ~s_q.pin_s[2];
    gate_lvl   = s_q.gate_s[1];
    async_mode = s_q.ctl.ext_sel & ~s_q.ctl.sync_en;
    run        = s_q.ctl.enable & ~(s_q.ctl.idle_stop & idle_mode);
    if (s_q.ctl.ext_sel) begin
      src_tick = ext_edge;
    end else if (s_q.ctl.gate_en) begin
      src_tick = gate_lvl;
    end else begin
      src_tick = 1'b1;
    end
    unique case (s_q.ctl.prescale)
      2'b00: ps_tc = `PS_DIV1_TC;
      2'b01: ps_tc = `PS_DIV8_TC;
      2'b10: ps_tc = `PS_DIV64_TC;
      2'b11: ps_tc = `PS_DIV256_TC;
    endcase
    // terminal by >= so a smaller prescale set mid-count cannot stall
    ps_tick = run & src_tick & (s_q.ps_cnt >= ps_tc);
  end

  // ----------------------------------------
  // register access decode
  // ----------------------------------------
  always_comb begin
    alias_sel = avs_address[3:2];
    reg_ofs   = {avs_address[15:4], 4'h0};
    wd16      = avs_writedata[15:0];
    acc       = (avs_read | avs_write) & s_q.wait_n;
    wr_go     = acc & avs_write;
    // read data loaded as the request is first seen, so it stands with the answer
    rd_go     = avs_read & ~s_q.wait_n;
    ctl_rd = 16'h0000;
    ctl_rd[`CTL_ENABLE_BIT]    = s_q.ctl.enable;
    ctl_rd[`CTL_IDLE_STOP_BIT] = s_q.ctl.idle_stop;
    ctl_rd[`CTL_WBLOCK_BIT]    = s_q.ctl.wblock;
    ctl_rd[`CTL_WPEND_BIT]     = s_q.wpend & async_mode;
    ctl_rd[`CTL_GATE_BIT]      = s_q.ctl.gate_en;
    ctl_rd[`CTL_PS_HI:`CTL_PS_LO] = s_q.ctl.prescale;
    ctl_rd[`CTL_SYNC_BIT]      = s_q.ctl.sync_en;
    ctl_rd[`CTL_CS_BIT]        = s_q.ctl.ext_sel;
    unique case (reg_ofs)
      `TMR_CONTROL_OFS: base_val = ctl_rd;
      `TMR_COUNT_OFS:   base_val = s_q.count;
      `TMR_PERIOD_OFS:  base_val = s_q.period;
      default:          base_val = 16'h0000;
    endcase
    unique case (alias_sel)
      `TMR_ALIAS_CLR: new_val = base_val & ~wd16;
      `TMR_ALIAS_SET: new_val = base_val | wd16;
      `TMR_ALIAS_INV: new_val = base_val ^ wd16;
      default:        new_val = wd16;
    endcase
    cnt_wr = wr_go & (reg_ofs == `TMR_COUNT_OFS)
             & ~(async_mode & s_q.ctl.wblock & s_q.wpend);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d          = s_q;
    ev           = 2'b00;
    s_d.pin_s    = {s_q.pin_s[1:0], external_timer_clock_pin};
    s_d.gate_s   = {s_q.gate_s[0], gate_pin};
    s_d.gate_prev = gate_lvl;

    if (run & src_tick) begin
      s_d.ps_cnt = (s_q.ps_cnt >= ps_tc) ? 8'h00 : s_q.ps_cnt + 8'h01;
    end
    if (!s_q.ctl.enable) begin
      s_d.ps_cnt = 8'h00;
    end

    if (ps_tick) begin
      if (s_q.count == s_q.period) begin
        s_d.count = 16'h0000;
        ev[0]     = 1'b1;
      end else begin
        s_d.count = s_q.count + 16'h0001;
      end
    end

    if (s_q.ctl.enable & ~s_q.ctl.ext_sel & s_q.ctl.gate_en & s_q.gate_prev & ~gate_lvl) begin
      ev[1] = 1'b1;
    end

    // async write completes after transfer delay
    if (s_q.wpend) begin
      if (s_q.wcnt == 3'h0) begin
        s_d.wpend = 1'b0;
        s_d.count = s_q.wdata;
      end else begin
        s_d.wcnt = s_q.wcnt - 3'h1;
      end
    end

    if (cnt_wr) begin
      if (async_mode) begin
        s_d.wpend = 1'b1;
        s_d.wcnt  = `ASYNC_WR_CYCLES - 3'h1;
        s_d.wdata = new_val;
      end else begin
        s_d.count = new_val;
        s_d.wpend = 1'b0;
      end
    end

    if (wr_go) begin
      unique case (reg_ofs)
        `TMR_CONTROL_OFS: begin
          s_d.ctl.enable    = new_val[`CTL_ENABLE_BIT];
          s_d.ctl.idle_stop = new_val[`CTL_IDLE_STOP_BIT];
          s_d.ctl.wblock    = new_val[`CTL_WBLOCK_BIT];
          s_d.ctl.gate_en   = new_val[`CTL_GATE_BIT];
          s_d.ctl.prescale  = new_val[`CTL_PS_HI:`CTL_PS_LO];
          s_d.ctl.sync_en   = new_val[`CTL_SYNC_BIT];
          s_d.ctl.ext_sel   = new_val[`CTL_CS_BIT];
        end
        `TMR_PERIOD_OFS: s_d.period = new_val;
        `TMR_IRQ_EN_OFS: s_d.irq_en = new_val[1:0];
        default: ;
      endcase
    end

    // set wins over clear
    if (wr_go & (reg_ofs == `TMR_IRQ_CLR_OFS) & (alias_sel == 2'h0)) begin
      s_d.irq_stat = s_q.irq_stat & ~wd16[1:0];
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq      = |(s_d.irq_stat & s_d.irq_en);

    // one wait cycle then answer
    s_d.wait_n = (avs_read | avs_write) & ~s_q.wait_n;
    if (rd_go) begin
      unique case (reg_ofs)
        `TMR_IRQ_STAT_OFS: s_d.rdata = {30'h0000_0000, s_q.irq_stat};
        `TMR_IRQ_EN_OFS:   s_d.rdata = {30'h0000_0000, s_q.irq_en};
        default:           s_d.rdata = {16'h0000, base_val};
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q        <= '0;
      s_q.period <= `PERIOD_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    avs_readdata    = s_q.rdata;
    avs_waitrequest = ~s_q.wait_n;
    timer_irq       = s_q.irq;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_disabled_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !s_q.ctl.enable & !s_q.wpend & !cnt_wr |=> $stable(s_q.count))
    else $error("count moved while disabled");
  a_idle_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_q.ctl.idle_stop & idle_mode |-> !ps_tick)
    else $error("tick during idle stop");
  a_block_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    async_mode & s_q.ctl.wblock & s_q.wpend & wr_go & (reg_ofs == `TMR_COUNT_OFS)
    |=> $stable(s_q.wdata) & (s_q.wcnt != `ASYNC_WR_CYCLES - 3'h1))
    else $error("blocked write accepted");
  a_backtoback: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !s_q.ctl.wblock & wr_go & (reg_ofs == `TMR_COUNT_OFS) |-> cnt_wr)
    else $error("write refused with block clear");
  a_pend_ends: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_q.wpend & (s_q.wcnt == 3'h0) & !cnt_wr
    |=> !s_q.wpend & (s_q.count == $past(s_q.wdata)))
    else $error("pending write did not land");
  a_sync_nopend: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !async_mode & !avs_waitrequest & avs_read & (reg_ofs == `TMR_CONTROL_OFS)
    |-> !avs_readdata[`CTL_WPEND_BIT])
    else $error("pending shown in sync mode");
  a_wrap_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ps_tick & (s_q.count == s_q.period) & !cnt_wr & !s_q.wpend
    |=> (s_q.count == 16'h0000) & s_q.irq_stat[0])
    else $error("period wrap wrong");
  a_upper_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !avs_waitrequest & avs_read & (reg_ofs != `TMR_IRQ_STAT_OFS)
    |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  a_gate_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_q.ctl.gate_en & !s_q.ctl.ext_sel & !gate_lvl |-> !ps_tick)
    else $error("gated tick with gate low");

  // ----------------------------------------
  // checks: clock source and prescaler
  // ----------------------------------------
  a_disable_psclr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !s_q.ctl.enable |=> (s_q.ps_cnt == 8'h00))
    else $error("prescaler kept while disabled");
  a_idle_runs: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_q.ctl.enable & !s_q.ctl.idle_stop & !s_q.ctl.ext_sel & !s_q.ctl.gate_en
    & (s_q.ps_cnt == ps_tc) |-> ps_tick)
    else $error("tick missed with idle stop clear");
  a_gate_ignored: assert property (@(posedge sys_clk) disable iff (!reset_n)
    run & s_q.ctl.ext_sel & s_q.ctl.gate_en & ext_edge & (s_q.ps_cnt == ps_tc)
    |-> ps_tick)
    else $error("gate used with external clock");
  a_gated_runs: assert property (@(posedge sys_clk) disable iff (!reset_n)
    run & !s_q.ctl.ext_sel & s_q.ctl.gate_en & gate_lvl & (s_q.ps_cnt == ps_tc)
    |-> ps_tick)
    else $error("gated tick missed with gate high");
  a_ps_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
    run & src_tick & (s_q.ps_cnt < ps_tc)
    |=> (s_q.ps_cnt == $past(s_q.ps_cnt) + 8'h01))
    else $error("prescaler did not step");
  a_ps_div1: assert property (@(posedge sys_clk) disable iff (!reset_n)
    run & src_tick & (s_q.ctl.prescale == 2'b00) |-> ps_tick)
    else $error("divide by one missed a tick");
  a_ps_div8: assert property (@(posedge sys_clk) disable iff (!reset_n)
    run & src_tick & (s_q.ctl.prescale == 2'b01) & (s_q.ps_cnt < `PS_DIV8_TC)
    |-> !ps_tick)
    else $error("divide by eight ticked early");
  a_ps_div64: assert property (@(posedge sys_clk) disable iff (!reset_n)
    run & src_tick & (s_q.ctl.prescale == 2'b10) & (s_q.ps_cnt < `PS_DIV64_TC)
    |-> !ps_tick)
    else $error("divide by sixty-four ticked early");
  a_ps_div256: assert property (@(posedge sys_clk) disable iff (!reset_n)
    run & src_tick & (s_q.ctl.prescale == 2'b11) & (s_q.ps_cnt < `PS_DIV256_TC)
    |-> !ps_tick)
    else $error("divide by 256 ticked early");
  a_ext_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_q.ctl.ext_sel & !ext_edge |-> !ps_tick)
    else $error("tick without external edge");
  a_sync_ignored: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !s_q.ctl.ext_sel |-> !async_mode)
    else $error("async mode with internal clock");

  // ----------------------------------------
  // checks: registers and events
  // ----------------------------------------
  a_pend_starts: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cnt_wr & async_mode |=> s_q.wpend)
    else $error("async write not pending");
  a_pend_bounded: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_q.wpend |-> (s_q.wcnt < `ASYNC_WR_CYCLES))
    else $error("pending transfer too long");
  a_ctl_unused: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !avs_waitrequest & avs_read & (reg_ofs == `TMR_CONTROL_OFS)
    |-> ((avs_readdata[15:0] & ~(`CTL_WRITABLE_MASK | (16'h0001 << `CTL_WPEND_BIT)))
         == 16'h0000))
    else $error("unimplemented control bit set");
  a_alias_clr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_go & (reg_ofs == `TMR_PERIOD_OFS) & (alias_sel == `TMR_ALIAS_CLR)
    |=> ((s_q.period & $past(wd16)) == 16'h0000))
    else $error("clear alias left bits set");
  a_alias_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_go & (reg_ofs == `TMR_PERIOD_OFS) & (alias_sel == `TMR_ALIAS_SET)
    |=> ((s_q.period & $past(wd16)) == $past(wd16)))
    else $error("set alias left bits clear");
  a_alias_inv: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_go & (reg_ofs == `TMR_PERIOD_OFS) & (alias_sel == `TMR_ALIAS_INV)
    |=> (s_q.period == ($past(s_q.period) ^ $past(wd16))))
    else $error("invert alias wrong");
  a_count_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ps_tick & (s_q.count != s_q.period) & !cnt_wr & !s_q.wpend
    |=> (s_q.count == $past(s_q.count) + 16'h0001))
    else $error("count did not step");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
    timer_irq == |(s_q.irq_stat & s_q.irq_en))
    else $error("interrupt level wrong");
  a_gate_fall: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_q.ctl.enable & !s_q.ctl.ext_sel & s_q.ctl.gate_en & s_q.gate_prev & !gate_lvl
    |=> s_q.irq_stat[1])
    else $error("gate fall not flagged");

endmodule

// File: hdl/async_timer_params.svh
`ifndef ASYNC_TIMER_PARAMS_SVH
`define ASYNC_TIMER_PARAMS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define TMR_CONTROL_OFS   16'h0600
`define TMR_COUNT_OFS     16'h0610
`define TMR_PERIOD_OFS    16'h0620
`define TMR_IRQ_STAT_OFS  16'h0630
`define TMR_IRQ_EN_OFS    16'h0640
`define TMR_IRQ_CLR_OFS   16'h0650
`define TMR_ALIAS_CLR     2'h1
`define TMR_ALIAS_SET     2'h2
`define TMR_ALIAS_INV     2'h3

// ----------------------------------------
// control field positions
// ----------------------------------------
`define CTL_ENABLE_BIT    15
`define CTL_IDLE_STOP_BIT 13
`define CTL_WBLOCK_BIT    12
`define CTL_WPEND_BIT     11
`define CTL_GATE_BIT      7
`define CTL_PS_HI         5
`define CTL_PS_LO         4
`define CTL_SYNC_BIT      2
`define CTL_CS_BIT        1
`define CTL_WRITABLE_MASK 16'hb0b6

// ----------------------------------------
// reset values
// ----------------------------------------
`define CONTROL_RESET     16'h0000
`define COUNT_RESET       16'h0000
`define PERIOD_RESET      16'hffff

// ----------------------------------------
// prescale terminal counts (divide minus one)
// ----------------------------------------
`define PS_DIV1_TC        8'h00
`define PS_DIV8_TC        8'h07
`define PS_DIV64_TC       8'h3f
`define PS_DIV256_TC      8'hff

// ----------------------------------------
// async counter write transfer time in cycles
// ----------------------------------------
`define ASYNC_WR_CYCLES   3'h3

`endif

// File: hdl/async_timer_pkg.sv
package async_timer_pkg;

  typedef struct packed {
    logic        enable;
    logic        idle_stop;
    logic        wblock;
    logic        gate_en;
    logic [1:0]  prescale;
    logic        sync_en;
    logic        ext_sel;
  } ctl_t;

  typedef struct packed {
    ctl_t        ctl;
    logic [15:0] count;
    logic [15:0] period;
    logic [7:0]  ps_cnt;
    logic        wpend;
    logic [2:0]  wcnt;
    logic [15:0] wdata;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_en;
    logic        irq;
    logic        wait_n;
    logic [31:0] rdata;
    logic [2:0]  pin_s;
    logic [1:0]  gate_s;
    logic        gate_prev;
  } state_t;

endpackage

// File: testbench/ext_source.sv
`timescale 1ns/10ps
// ----------------------------------------
// far-side pin source: clock pulses, gate
// ----------------------------------------
module ext_source (
  input  wire logic       sys_clk,
  input  wire logic       start,
  input  wire logic [7:0] n_pulses,
  input  wire logic [7:0] gate_cycles,
  output logic            ext_clk,
  output logic            gate
);
  initial begin
    ext_clk = 1'b0;
    gate    = 1'b0;
  end
  always @(posedge start) begin
    repeat (8) @(posedge sys_clk);
    repeat (n_pulses) begin
      repeat (3) @(posedge sys_clk);
      ext_clk <= 1'b1;
      repeat (3) @(posedge sys_clk);
      ext_clk <= 1'b0;
    end
    // gate high for a fixed time
    if (gate_cycles != 8'h00) begin
      gate <= 1'b1;
      repeat (gate_cycles) @(posedge sys_clk);
      gate <= 1'b0;
    end
  end
endmodule

// File: testbench/async_timer_tb.sv
`timescale 1ns/10ps
module async_timer_tb;
  logic        sys_clk       = 1'b0;
  logic        reset_n       = 1'b0;
  logic [15:0] avs_address   = 16'h0000;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        idle_mode     = 1'b0;
  logic        ext_pin;
  logic        gate_pin;
  logic        timer_irq;
  logic        src_start     = 1'b0;
  logic [7:0]  src_pulses    = 8'h00;
  logic [7:0]  src_gate      = 8'h00;
  logic [31:0] rd;
  int          mismatches    = 0;
  int          checked       = 0;

  always #5 sys_clk = ~sys_clk;

  async_timer i_dut (
    .sys_clk                  (sys_clk),
    .reset_n                  (reset_n),
    .avs_address              (avs_address),
    .avs_read                 (avs_read),
    .avs_write                (avs_write),
    .avs_writedata            (avs_writedata),
    .avs_readdata             (avs_readdata),
    .avs_waitrequest          (avs_waitrequest),
    .idle_mode                (idle_mode),
    .external_timer_clock_pin (ext_pin),
    .gate_pin                 (gate_pin),
    .timer_irq                (timer_irq)
  );

  ext_source i_src (
    .sys_clk     (sys_clk),
    .start       (src_start),
    .n_pulses    (src_pulses),
    .gate_cycles (src_gate),
    .ext_clk     (ext_pin),
    .gate        (gate_pin)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_rng(input string name, input int lo, input int hi, input logic [31:0] got);
    checked++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      mismatches++;
      $display("BAD %s expected %0d..%0d seen %h", name, lo, hi, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      $display("BAD waitrequest expected 0 seen 1");
      stop_test();
    end
  endtask

  // clear count, run with ctl for cyc cycles, stop, read count into rd
  task automatic run(input logic [15:0] ctl, input int cyc);
    bus(1'b1, 16'h0610, 32'h0000_0000);
    src_start <= 1'b1;
    bus(1'b1, 16'h0600, {16'h0000, ctl});
    repeat (cyc) @(posedge sys_clk);
    bus(1'b1, 16'h0600, 32'h0000_0000);
    src_start <= 1'b0;
    // bus task leaves a cycle after disable
    bus(1'b0, 16'h0610, 32'h0000_0000);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic regs_test;
    bus(1'b0, 16'h0600, 32'h0000_0000); chk("control", 32'h0000_0000, rd);
    bus(1'b0, 16'h0610, 32'h0000_0000); chk("count", 32'h0000_0000, rd);
    bus(1'b0, 16'h0620, 32'h0000_0000); chk("period", 32'h0000_ffff, rd);
    bus(1'b0, 16'h0700, 32'h0000_0000); chk("unmapped", 32'h0000_0000, rd);
    bus(1'b1, 16'h0600, 32'hffff_ffff);
    bus(1'b0, 16'h0600, 32'h0000_0000); chk("control", 32'h0000_b0b6, rd);
    bus(1'b1, 16'h0604, 32'h0000_ffff);
    bus(1'b0, 16'h0600, 32'h0000_0000); chk("clr alias", 32'h0000_0000, rd);
    bus(1'b1, 16'h0608, 32'h0000_0010);
    bus(1'b1, 16'h060c, 32'h0000_0030);
    bus(1'b0, 16'h0600, 32'h0000_0000); chk("set inv", 32'h0000_0020, rd);
    bus(1'b1, 16'h0624, 32'h0000_ff00);
    bus(1'b0, 16'h0620, 32'h0000_0000); chk("period clr", 32'h0000_00ff, rd);
    bus(1'b1, 16'h0600, 32'h0000_0000);
  endtask

  task automatic prescale_test;
    int div[4];
    div = '{1, 8, 64, 256};
    idle_mode <= 1'b1;
    bus(1'b1, 16'h0620, 32'h0000_ffff);
    for (int k = 0; k < 4; k++) begin
      run(16'h8000 | (16'(k) << 4), 512);
      chk_rng("count", 512 / div[k], 512 / div[k] + 6, rd);
    end
    run(16'ha000, 100); chk("idle count", 32'h0000_0000, rd);
    run(16'h0000, 100); chk("off count", 32'h0000_0000, rd);
    idle_mode <= 1'b0;
  endtask

  task automatic irq_test;
    bus(1'b1, 16'h0620, 32'h0000_0009);
    run(16'h8000, 40); chk_rng("wrap count", 0, 9, rd);
    bus(1'b0, 16'h0630, 32'h0000_0000); chk("status", 32'h0000_0001, rd & 32'h1);
    chk("irq masked", 32'h0000_0000, {31'h0, timer_irq});
    bus(1'b1, 16'h0640, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0000_0001, {31'h0, timer_irq});
    bus(1'b1, 16'h0650, 32'h0000_0003);
    repeat (2) @(posedge sys_clk);
    chk("irq clr", 32'h0000_0000, {31'h0, timer_irq});
    bus(1'b1, 16'h0620, 32'h0000_ffff);
  endtask

  task automatic pin_test;
    src_pulses <= 8'd20;
    run(16'h8086, 200); chk("sync ext", 32'h0000_0014, rd);
    src_pulses <= 8'd10;
    run(16'h8002, 200); chk("async ext", 32'h0000_000a, rd);
    src_pulses <= 8'd0;
    src_gate   <= 8'd100;
    run(16'h8080, 150); chk_rng("gated", 100, 101, rd);
    bus(1'b0, 16'h0630, 32'h0000_0000); chk("gate fall", 32'h0000_0002, rd & 32'h2);
    src_gate   <= 8'd0;
    bus(1'b1, 16'h0600, 32'h0000_8002);
    bus(1'b1, 16'h0610, 32'h0000_1234);
    bus(1'b1, 16'h0610, 32'h0000_5678);
    repeat (10) @(posedge sys_clk);
    bus(1'b0, 16'h0610, 32'h0000_0000); chk("back to back", 32'h0000_5678, rd);
    bus(1'b0, 16'h0600, 32'h0000_0000); chk("wpend done", 32'h0000_8002, rd);
    bus(1'b1, 16'h0610, 32'h0000_4321);
    bus(1'b0, 16'h0600, 32'h0000_0000); chk("wpend busy", 32'h0000_8802, rd);
    bus(1'b1, 16'h0600, 32'h0000_9002);
    bus(1'b1, 16'h0610, 32'h0000_1111);
    bus(1'b1, 16'h0610, 32'h0000_2222);
    repeat (10) @(posedge sys_clk);
    bus(1'b0, 16'h0610, 32'h0000_0000); chk("blocked", 32'h0000_1111, rd);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    regs_test();
    prescale_test();
    irq_test();
    pin_test();
    stop_test();
  end
endmodule
